// ---- gfs_pkg.sv ----
// Constants and types shared by the gauge flag, seal and error block
package gfs_pkg;

  // ---------------------------------------------------------------
  // Bit positions of the status low byte
  // ---------------------------------------------------------------
  localparam int unsigned BIT_TEMP_RATE = 7;
  localparam int unsigned BIT_TAPER     = 6;
  localparam int unsigned BIT_VALID_CHG = 5;
  localparam int unsigned BIT_VALID_DIS = 3;
  localparam int unsigned BIT_OVERLOAD  = 2;
  localparam int unsigned BIT_FIRST_EDV = 1;
  localparam int unsigned BIT_FINAL_EDV = 0;
  localparam logic [7:0]  FLAGS_RST     = 8'h00;

  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] CMD_WR_FIRST  = 8'h00;
  localparam logic [7:0] CMD_WR_LAST   = 8'h04;
  localparam logic [7:0] CMD_BATT_STAT = 8'h16;
  localparam logic [7:0] CMD_STD_LAST  = 8'h23;
  localparam logic [7:0] CMD_FLAGS     = 8'h2F;
  localparam logic [7:0] CMD_MFG_FIRST = 8'h3C;
  localparam logic [7:0] CMD_MFG_LAST  = 8'h3F;
  localparam int unsigned NUM_WR_REGS  = 5;

  // ---------------------------------------------------------------
  // Seal configuration
  // ---------------------------------------------------------------
  localparam logic [7:0] CFG_SEAL_ADDR = 8'h3D;
  localparam logic [7:0] CFG_SEAL_KEY  = 8'hB0;

  // ---------------------------------------------------------------
  // Bus constants
  // ---------------------------------------------------------------
  localparam logic [6:0]  DEV_ADDR_DEF = 7'h0B;
  localparam logic [15:0] RD_FILL      = 16'hFFFF;
  localparam logic [15:0] WR_REG_RST   = 16'h0000;
  localparam logic [3:0]  BITS_BYTE    = 4'h8;
  localparam logic [2:0]  WORD_BYTES   = 3'h2;

  // ---------------------------------------------------------------
  // Error codes, reported in the low nibble of the status word
  // ---------------------------------------------------------------
  localparam logic [3:0] ERR_OK          = 4'h0;
  localparam logic [3:0] ERR_BUSY        = 4'h1;
  localparam logic [3:0] ERR_RESERVED    = 4'h2;
  localparam logic [3:0] ERR_UNSUPPORTED = 4'h3;
  localparam logic [3:0] ERR_ACCESS_DEN  = 4'h4;
  localparam logic [3:0] ERR_OVER_UNDER  = 4'h5;
  localparam logic [3:0] ERR_BAD_SIZE    = 4'h6;
  localparam logic [3:0] ERR_UNKNOWN     = 4'h7;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } gfs_state_type;

endpackage

// ---- gfs_flags_seal.sv ----
// Status low byte, seal control and error reporting behind the two-wire bus
`timescale 1ns/100ps

// Notes on behaviour
// - Bit 7 follows temperature rate above limit
// - Bit 6 follows current taper termination detect
// - Valid charge: sense at threshold plus 10mAh
// - Valid discharge set on first discharge after full
// - Valid discharge cleared: partial, cold first_end_discharge_flag, selfdischarge
// - Overload: set discharge current above rate, clear below rate
// - First edv: set low unloaded, clear charged
// - Final edv: set low unloaded, clear charged
// - Seal when config location 3D holds B0
// - Sealed: writes only to commands 00..04
// - Sealed: other writes get data not acknowledged
// - Sealed: reads standard set plus 2F, 3C..3F
// - Clean command reports code zero
// - Not ready to service reports busy
// - Data not available yet reports reserved
// - Unimplemented command reports unsupported
// - Write to read-only command reports denied
// - Data overrun reports overflow code
// - Wrong write length reports bad size
// - Reading error code then clears it
// - Flags word: low byte status, high byte other
module gfs_flags_seal #(
  parameter logic [6:0] DEV_ADDR = gfs_pkg::DEV_ADDR_DEF
) (
  // System clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Measurement front end, on its own clock
  input  wire logic        meas_clk,
  input  wire logic        meas_valid,
  input  wire logic        temp_rate_high,
  input  wire logic        taper_detect,
  input  wire logic        sense_at_or_above,
  input  wire logic        sense_at_or_below,
  input  wire logic        charge_10mah_done,
  input  wire logic        discharging,
  input  wire logic        partial_charge,
  input  wire logic        remaining_at_full,
  input  wire logic        below_freezing,
  input  wire logic        self_dis_over,
  input  wire logic        dis_above_rate,
  input  wire logic        dis_below_rate,
  input  wire logic        volt_below_first,
  input  wire logic        volt_above_first,
  input  wire logic        volt_below_final,
  input  wire logic        volt_above_final,
  // Configuration loader
  input  wire logic        cfg_wr,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [7:0]  cfg_data,
  input  wire logic        cfg_done,
  // Other status from the gauge core
  input  wire logic [7:0]  status_high_byte,
  input  wire logic [11:0] battery_status_bits,
  // Two-wire bus pins
  input  wire logic        smbc_i,
  input  wire logic        smbd_i,
  output logic             smbd_o,
  output logic             smbd_oe,
  // Status outputs
  output logic [7:0]       status_low_byte,
  output logic             sealed_access_mode,
  output logic [3:0]       error_code
);

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic in_range(input logic [7:0] c, input logic [7:0] lo,
                                    input logic [7:0] hi);
    in_range = (c >= lo) && (c <= hi);
  endfunction

  function automatic logic is_writable(input logic [7:0] c);
    is_writable = in_range(c, gfs_pkg::CMD_WR_FIRST, gfs_pkg::CMD_WR_LAST);
  endfunction

  function automatic logic is_implemented(input logic [7:0] c);
    is_implemented = is_writable(c) || (c == gfs_pkg::CMD_BATT_STAT) ||
                     (c == gfs_pkg::CMD_FLAGS);
  endfunction

  function automatic logic sealed_read_ok(input logic [7:0] c);
    sealed_read_ok = in_range(c, gfs_pkg::CMD_WR_FIRST, gfs_pkg::CMD_STD_LAST) ||
                     (c == gfs_pkg::CMD_FLAGS) ||
                     in_range(c, gfs_pkg::CMD_MFG_FIRST, gfs_pkg::CMD_MFG_LAST);
  endfunction

  // ---------------------------------------------------------------
  // Measurement domain: capture a sample and hand it over
  // ---------------------------------------------------------------
  logic        mrst_meta_ff;
  logic        mrst_ff;
  logic        m_req_ff;
  logic        m_ack_meta_ff;
  logic        m_ack_ff;
  logic [15:0] m_cond_ff;
  logic [15:0] m_cond_now;

  assign m_cond_now = {temp_rate_high, taper_detect, sense_at_or_above, sense_at_or_below,
                       charge_10mah_done, discharging, partial_charge, remaining_at_full,
                       below_freezing, self_dis_over, dis_above_rate, dis_below_rate,
                       volt_below_first, volt_above_first, volt_below_final,
                       volt_above_final};

  always_ff @(posedge meas_clk) begin
    mrst_meta_ff <= srst;
    mrst_ff      <= mrst_meta_ff;
  end

  always_ff @(posedge meas_clk) begin
    m_ack_meta_ff <= s_ack_ff;
    m_ack_ff      <= m_ack_meta_ff;
  end

  // Sample word is held stable until the system side acknowledges it;
  // samples offered meanwhile are dropped, the next one carries the news
  always_ff @(posedge meas_clk) begin
    if (mrst_ff) begin
      m_req_ff  <= 1'b0;
      m_cond_ff <= 16'h0000;
    end else if (meas_valid && (m_req_ff == m_ack_ff)) begin
      m_req_ff  <= ~m_req_ff;
      m_cond_ff <= m_cond_now;
    end
  end

  // ---------------------------------------------------------------
  // System domain: take the sample and update the status low byte
  // ---------------------------------------------------------------
  logic        s_req_meta_ff;
  logic        s_req_ff;
  logic        s_ack_ff;
  logic        upd;
  logic [15:0] c;
  logic [7:0]  flags_ff;
  logic [7:0]  nxt_flags;
  logic        full_armed_ff;
  logic        flags_valid_ff;

  always_ff @(posedge clk) begin
    s_req_meta_ff <= m_req_ff;
    s_req_ff      <= s_req_meta_ff;
  end

  assign upd = (s_req_ff != s_ack_ff);
  assign c   = m_cond_ff;

  always_ff @(posedge clk) begin
    if (srst) begin
      s_ack_ff <= 1'b0;
    end else if (upd) begin
      s_ack_ff <= s_req_ff;
    end
  end

  always_comb begin
    nxt_flags = flags_ff;
    nxt_flags[gfs_pkg::BIT_TEMP_RATE] = c[15];
    nxt_flags[gfs_pkg::BIT_TAPER]     = c[14];
    if (c[10] || c[12]) begin
      nxt_flags[gfs_pkg::BIT_VALID_CHG] = 1'b0;
    end else if (c[13] && c[11]) begin
      nxt_flags[gfs_pkg::BIT_VALID_CHG] = 1'b1;
    end
    if (c[5]) begin
      nxt_flags[gfs_pkg::BIT_OVERLOAD] = 1'b1;
    end else if (c[4]) begin
      nxt_flags[gfs_pkg::BIT_OVERLOAD] = 1'b0;
    end
    if (c[3] && !flags_ff[gfs_pkg::BIT_OVERLOAD]) begin
      nxt_flags[gfs_pkg::BIT_FIRST_EDV] = 1'b1;
    end else if (flags_ff[gfs_pkg::BIT_VALID_CHG] && c[2]) begin
      nxt_flags[gfs_pkg::BIT_FIRST_EDV] = 1'b0;
    end
    if (c[1] && !flags_ff[gfs_pkg::BIT_OVERLOAD]) begin
      nxt_flags[gfs_pkg::BIT_FINAL_EDV] = 1'b1;
    end else if (flags_ff[gfs_pkg::BIT_VALID_CHG] && c[0]) begin
      nxt_flags[gfs_pkg::BIT_FINAL_EDV] = 1'b0;
    end
    // Losing the learning cycle outranks starting one
    if (c[9] || c[6] || nxt_flags[gfs_pkg::BIT_VALID_CHG] ||
        (c[7] && nxt_flags[gfs_pkg::BIT_FIRST_EDV] && !flags_ff[gfs_pkg::BIT_FIRST_EDV])) begin
      nxt_flags[gfs_pkg::BIT_VALID_DIS] = 1'b0;
    end else if (c[10] && full_armed_ff) begin
      nxt_flags[gfs_pkg::BIT_VALID_DIS] = 1'b1;
    end
    nxt_flags[4] = 1'b0;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      flags_ff       <= gfs_pkg::FLAGS_RST;
      flags_valid_ff <= 1'b0;
    end else if (upd) begin
      flags_ff       <= nxt_flags;
      flags_valid_ff <= 1'b1;
    end
  end

  // Armed at full capacity, spent by the first discharge that follows
  always_ff @(posedge clk) begin
    if (srst) begin
      full_armed_ff <= 1'b0;
    end else if (upd) begin
      if (c[8]) begin
        full_armed_ff <= 1'b1;
      end else if (c[10]) begin
        full_armed_ff <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // Seal configuration
  // ---------------------------------------------------------------
  logic sealed_ff;

  always_ff @(posedge clk) begin
    if (srst) begin
      sealed_ff <= 1'b0;
    end else if (cfg_wr && (cfg_addr == gfs_pkg::CFG_SEAL_ADDR)) begin
      sealed_ff <= (cfg_data == gfs_pkg::CFG_SEAL_KEY);
    end
  end

  // ---------------------------------------------------------------
  // Bus pin synchronisers and edge detect
  // ---------------------------------------------------------------
  logic scl_meta_ff;
  logic scl_ff;
  logic scl_d_ff;
  logic sda_meta_ff;
  logic sda_ff;
  logic sda_d_ff;
  logic scl_rise;
  logic scl_fall;
  logic bus_start;
  logic bus_stop;

  always_ff @(posedge clk) begin
    if (srst) begin
      scl_meta_ff <= 1'b1;
      scl_ff      <= 1'b1;
      scl_d_ff    <= 1'b1;
      sda_meta_ff <= 1'b1;
      sda_ff      <= 1'b1;
      sda_d_ff    <= 1'b1;
    end else begin
      scl_meta_ff <= smbc_i;
      scl_ff      <= scl_meta_ff;
      scl_d_ff    <= scl_ff;
      sda_meta_ff <= smbd_i;
      sda_ff      <= sda_meta_ff;
      sda_d_ff    <= sda_ff;
    end
  end

  assign scl_rise  = scl_ff && !scl_d_ff;
  assign scl_fall  = !scl_ff && scl_d_ff;
  assign bus_start = scl_ff && scl_d_ff && sda_d_ff && !sda_ff;
  assign bus_stop  = scl_ff && scl_d_ff && !sda_d_ff && sda_ff;

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  gfs_pkg::gfs_state_type state_ff;
  logic [3:0]  bit_cnt_ff;
  logic [7:0]  shift_ff;
  logic [7:0]  cmd_ff;
  logic        is_read_ff;
  logic        have_cmd_ff;
  logic        rd_done_ff;
  logic        rd_over_ff;
  logic        refused_ff;
  logic        aborted_ff;
  logic [2:0]  wcnt_ff;
  logic [2:0]  rcnt_ff;
  logic [7:0]  wlo_ff;
  logic [7:0]  whi_ff;
  logic [15:0] rd_word_ff;
  logic        oe_ff;
  logic [15:0] rd_mux;
  logic        wr_allowed;
  logic [3:0]  err_ff;
  logic [15:0] wr_regs_ff [gfs_pkg::NUM_WR_REGS];

  // Flags word places the status low byte underneath the high byte
  always_comb begin
    if (is_writable(cmd_ff)) begin
      rd_mux = wr_regs_ff[cmd_ff[2:0]];
    end else if (cmd_ff == gfs_pkg::CMD_BATT_STAT) begin
      rd_mux = {battery_status_bits, err_ff};
    end else if (cmd_ff == gfs_pkg::CMD_FLAGS) begin
      rd_mux = {status_high_byte, flags_ff};
    end else begin
      rd_mux = gfs_pkg::RD_FILL;
    end
  end

  assign wr_allowed = !sealed_ff || is_writable(cmd_ff);

  always_ff @(posedge clk) begin
    if (srst || bus_stop) begin
      state_ff    <= gfs_pkg::ST_IDLE;
      oe_ff       <= 1'b0;
      bit_cnt_ff  <= 4'h0;
      shift_ff    <= 8'h00;
      is_read_ff  <= 1'b0;
      rd_word_ff  <= 16'h0000;
    end else if (bus_start) begin
      state_ff   <= gfs_pkg::ST_ADDR;
      oe_ff      <= 1'b0;
      bit_cnt_ff <= 4'h0;
    end else begin
      case (state_ff)
        gfs_pkg::ST_ADDR, gfs_pkg::ST_CMD, gfs_pkg::ST_WDATA: begin
          if (scl_rise) begin
            shift_ff   <= {shift_ff[6:0], sda_ff};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (scl_fall && (bit_cnt_ff == gfs_pkg::BITS_BYTE)) begin
            bit_cnt_ff <= 4'h0;
            if (state_ff == gfs_pkg::ST_ADDR) begin
              if (shift_ff[7:1] == DEV_ADDR) begin
                oe_ff      <= 1'b1;
                is_read_ff <= shift_ff[0];
                rd_word_ff <= rd_mux;
                state_ff   <= gfs_pkg::ST_ADDR_ACK;
              end else begin
                state_ff <= gfs_pkg::ST_IDLE;
              end
            end else if (state_ff == gfs_pkg::ST_CMD) begin
              oe_ff    <= 1'b1;
              state_ff <= gfs_pkg::ST_CMD_ACK;
            end else if (wr_allowed) begin
              oe_ff    <= 1'b1;
              state_ff <= gfs_pkg::ST_WDATA_ACK;
            end else begin
              state_ff <= gfs_pkg::ST_IDLE;
            end
          end
        end
        gfs_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (is_read_ff) begin
              shift_ff <= rd_word_ff[7:0];
              oe_ff    <= ~rd_word_ff[7];
              state_ff <= gfs_pkg::ST_RDATA;
            end else begin
              oe_ff    <= 1'b0;
              state_ff <= gfs_pkg::ST_CMD;
            end
          end
        end
        gfs_pkg::ST_CMD_ACK, gfs_pkg::ST_WDATA_ACK: begin
          if (scl_fall) begin
            oe_ff    <= 1'b0;
            state_ff <= gfs_pkg::ST_WDATA;
          end
        end
        gfs_pkg::ST_RDATA: begin
          if (scl_rise) begin
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt_ff == gfs_pkg::BITS_BYTE) begin
              oe_ff      <= 1'b0;
              bit_cnt_ff <= 4'h0;
              state_ff   <= gfs_pkg::ST_RDATA_ACK;
            end else begin
              shift_ff <= {shift_ff[6:0], 1'b0};
              oe_ff    <= ~shift_ff[6];
            end
          end
        end
        gfs_pkg::ST_RDATA_ACK: begin
          if (scl_rise && sda_ff) begin
            state_ff <= gfs_pkg::ST_IDLE;
          end else if (scl_fall) begin
            // Bytes past the word are filled with ones
            shift_ff <= (rcnt_ff == 3'h1) ? rd_word_ff[15:8] : gfs_pkg::RD_FILL[7:0];
            oe_ff    <= (rcnt_ff == 3'h1) ? ~rd_word_ff[15] : 1'b0;
            state_ff <= gfs_pkg::ST_RDATA;
          end
        end
        default: begin
          oe_ff <= 1'b0;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Transaction record, cleared when a stop closes the transaction
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst || bus_stop) begin
      have_cmd_ff <= 1'b0;
      rd_done_ff  <= 1'b0;
      rd_over_ff  <= 1'b0;
      refused_ff  <= 1'b0;
      aborted_ff  <= 1'b0;
      wcnt_ff     <= 3'h0;
      rcnt_ff     <= 3'h0;
    end else if (bus_start) begin
      // A clean repeated start or stop comes at most one clock rise into the next byte
      aborted_ff <= aborted_ff || (bit_cnt_ff > 4'h1);
      rcnt_ff    <= 3'h0;
    end else if (scl_fall && (bit_cnt_ff == gfs_pkg::BITS_BYTE)) begin
      if (state_ff == gfs_pkg::ST_CMD) begin
        cmd_ff      <= shift_ff;
        have_cmd_ff <= 1'b1;
        wcnt_ff     <= 3'h0;
      end else if (state_ff == gfs_pkg::ST_WDATA) begin
        refused_ff <= refused_ff || !wr_allowed;
        if (wcnt_ff == 3'h0) begin
          wlo_ff <= shift_ff;
        end
        if (wcnt_ff == 3'h1) begin
          whi_ff <= shift_ff;
        end
        if (wcnt_ff != 3'h7) begin
          wcnt_ff <= wcnt_ff + 3'h1;
        end
      end else if (state_ff == gfs_pkg::ST_RDATA) begin
        rd_done_ff <= 1'b1;
        if (rcnt_ff != 3'h7) begin
          rcnt_ff <= rcnt_ff + 3'h1;
        end
        rd_over_ff <= rd_over_ff || (rcnt_ff >= gfs_pkg::WORD_BYTES);
      end
    end
  end

  // ---------------------------------------------------------------
  // Error code and write commit, evaluated at stop
  // ---------------------------------------------------------------
  logic [3:0] nxt_err;
  logic       commit;

  always_comb begin
    nxt_err = err_ff;
    commit  = 1'b0;
    if (aborted_ff || (bit_cnt_ff > 4'h1)) begin
      nxt_err = gfs_pkg::ERR_UNKNOWN;
    end else if (rd_done_ff) begin
      if (!cfg_done) begin
        nxt_err = gfs_pkg::ERR_BUSY;
      end else if (!is_implemented(cmd_ff) || (sealed_ff && !sealed_read_ok(cmd_ff))) begin
        nxt_err = gfs_pkg::ERR_UNSUPPORTED;
      end else if (rd_over_ff) begin
        nxt_err = gfs_pkg::ERR_OVER_UNDER;
      end else if ((cmd_ff == gfs_pkg::CMD_FLAGS) && !flags_valid_ff) begin
        nxt_err = gfs_pkg::ERR_RESERVED;
      end else begin
        nxt_err = gfs_pkg::ERR_OK;
      end
    end else if (have_cmd_ff) begin
      if (!cfg_done) begin
        nxt_err = gfs_pkg::ERR_BUSY;
      end else if (refused_ff || (is_implemented(cmd_ff) && !is_writable(cmd_ff))) begin
        nxt_err = gfs_pkg::ERR_ACCESS_DEN;
      end else if (!is_implemented(cmd_ff)) begin
        nxt_err = gfs_pkg::ERR_UNSUPPORTED;
      end else if (wcnt_ff != gfs_pkg::WORD_BYTES) begin
        nxt_err = gfs_pkg::ERR_BAD_SIZE;
      end else begin
        nxt_err = gfs_pkg::ERR_OK;
        commit  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      err_ff <= gfs_pkg::ERR_OK;
    end else if (bus_stop && (rd_done_ff || have_cmd_ff || aborted_ff)) begin
      err_ff <= nxt_err;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      for (int i = 0; i < gfs_pkg::NUM_WR_REGS; i++) begin
        wr_regs_ff[i] <= gfs_pkg::WR_REG_RST;
      end
    end else if (bus_stop && commit) begin
      wr_regs_ff[cmd_ff[2:0]] <= {whi_ff, wlo_ff};
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (srst) begin
      smbd_o             <= 1'b0;
      smbd_oe            <= 1'b0;
      status_low_byte    <= gfs_pkg::FLAGS_RST;
      sealed_access_mode <= 1'b0;
      error_code         <= gfs_pkg::ERR_OK;
    end else begin
      smbd_o             <= 1'b0;
      smbd_oe            <= oe_ff;
      status_low_byte    <= flags_ff;
      sealed_access_mode <= sealed_ff;
      error_code         <= err_ff;
    end
  end

endmodule

// ---- gfs_flags_seal_props.sv ----
// Port assertions for the flag, seal and error block
`timescale 1ns/100ps
module gfs_props (
  input wire logic clk, srst, cfg_wr, smbd_o, sealed_access_mode,
  input wire logic [7:0] cfg_addr, cfg_data, status_low_byte,
  input wire logic [3:0] error_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence seal_wr;
    cfg_wr && cfg_addr == gfs_pkg::CFG_SEAL_ADDR;
  endsequence
  sequence cfg_quiet;
    !cfg_wr ##1 !cfg_wr ##1 !cfg_wr;
  endsequence
  chk_seal_enter: assert property (
    seal_wr ##0 cfg_data == gfs_pkg::CFG_SEAL_KEY |-> ##2 sealed_access_mode)
    else $error("seal not entered");
  chk_seal_leave: assert property (
    seal_wr ##0 cfg_data != gfs_pkg::CFG_SEAL_KEY |-> ##2 !sealed_access_mode)
    else $error("seal not left");
  chk_seal_hold: assert property (cfg_quiet |-> $stable(sealed_access_mode))
    else $error("seal moved without config write");
  // Open drain: the pin may only ever be pulled low
  chk_data_low: assert property (smbd_o == 1'b0)
    else $error("data pin driven high");
  chk_bit4_zero: assert property (status_low_byte[4] == 1'b0)
    else $error("reserved status bit set");
  chk_err_known: assert property (error_code <= gfs_pkg::ERR_UNKNOWN)
    else $error("error code out of range");
  chk_first_end_discharge_flag_set: assert property ($rose(status_low_byte[1]) |-> !$past(status_low_byte[2]))
    else $error("first end flag set under overload");
  chk_final_end_discharge_flag_set: assert property ($rose(status_low_byte[0]) |-> !$past(status_low_byte[2]))
    else $error("final end flag set under overload");
endmodule
bind gfs_flags_seal gfs_props gfs_props_inst (.*);

// ---- gfs_host_model.sv ----
// Two-wire bus host driving the clock and data pins
`timescale 1ns/100ps
module gfs_host_model (
  input wire logic clk,
  input wire logic sda,
  output logic scl = 1'b1,
  output logic sda_oe = 1'b0
);
  // Six clocks a step gives a six-clock high phase and a twelve-clock low phase, both above the four-clock minimum
  task automatic half;
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic bits(input logic [7:0] d, input logic a, output logic [7:0] q, output logic r);
    for (int i = 7; i >= -1; i--) begin
      sda_oe = (i < 0) ? !a : !d[i];
      half;
      scl = 1'b1;
      half;
      if (i < 0) r = sda;
      else q[i] = sda;
      scl = 1'b0;
      half;
    end
  endtask
  task automatic edge_seq(input logic st);
    sda_oe = !st;
    half;
    scl = 1'b1;
    half;
    sda_oe = st;
    half;
    if (st) scl = 1'b0;
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input int n, output logic k);
    logic [7:0] q;
    logic r;
    edge_seq(1'b1);
    bits({gfs_pkg::DEV_ADDR_DEF, 1'b0}, 1'b1, q, k);
    bits(c, 1'b1, q, r);
    k = k | r;
    for (int i = 0; i < n; i++) begin
      bits(d[8*i+:8], 1'b1, q, r);
      k = k | r;
    end
    edge_seq(1'b0);
  endtask
  task automatic rd(input logic [7:0] c, input int n, output logic [15:0] d);
    logic [7:0] q;
    logic r;
    edge_seq(1'b1);
    bits({gfs_pkg::DEV_ADDR_DEF, 1'b0}, 1'b1, q, r);
    bits(c, 1'b1, q, r);
    edge_seq(1'b1);
    bits({gfs_pkg::DEV_ADDR_DEF, 1'b1}, 1'b1, q, r);
    bits(8'hFF, 1'b0, d[7:0], r);
    bits(8'hFF, n < 3, d[15:8], r);
    if (n > 2) bits(8'hFF, 1'b1, q, r);
    edge_seq(1'b0);
  endtask
endmodule

// ---- gfs_flags_seal_bench.sv ----
// Self-checking bench for the flag, seal and error block
`timescale 1ns/100ps
module gfs_flags_seal_bench;
  logic clk = 0, meas_clk = 0, srst = 1, meas_valid = 0, cfg_wr = 0, cfg_done = 0, nak, arm = 0;
  logic [7:0] cfg_addr = 8'h00, cfg_data = 8'h00, status_high_byte = 8'h00, exp_f = 8'h00;
  logic [11:0] battery_status_bits = 12'h000;
  logic [15:0] mv = 16'h0000, rdat, rnd = 16'h0000;
  logic temp_rate_high, taper_detect, sense_at_or_above, sense_at_or_below, charge_10mah_done;
  logic discharging, partial_charge, remaining_at_full, below_freezing, self_dis_over;
  logic dis_above_rate, dis_below_rate, volt_below_first, volt_above_first;
  logic volt_below_final, volt_above_final, smbc_i, smbd_i, smbd_o, smbd_oe, sda_oe;
  logic sealed_access_mode;
  logic [7:0] status_low_byte;
  logic [3:0] error_code;
  int n_errors = 0, total_checks = 0, seed = 3, cyc = 0;
  logic [15:0] vec [10] = '{16'hC000, 16'h002A, 16'h0010, 16'h2800, 16'h0005,
                            16'h1100, 16'h0500, 16'h0200, 16'h0500, 16'h0540};
  assign {temp_rate_high, taper_detect, sense_at_or_above, sense_at_or_below, charge_10mah_done,
          discharging, partial_charge, remaining_at_full, below_freezing, self_dis_over,
          dis_above_rate, dis_below_rate, volt_below_first, volt_above_first,
          volt_below_final, volt_above_final} = mv;
  // Pull-up on the data line: low whenever either side pulls
  assign smbd_i = !(sda_oe | smbd_oe);
  gfs_flags_seal gfs_flags_seal_inst (.*);
  gfs_host_model gfs_host_model_inst (.clk(clk), .sda(smbd_i), .scl(smbc_i), .sda_oe(sda_oe));
  initial forever #4 clk = !clk;
  initial begin
    #5;
    forever #24 meas_clk = !meas_clk;
  end
  function automatic logic [7:0] nf(logic [7:0] o, logic [15:0] m, logic a);
    logic q, d, v, e1, e0;
    q = !(m[10] | m[12]) & (o[5] | m[13] & m[11]);
    v = m[5] | o[2] & !m[4];
    e1 = m[3] & !o[2] | o[1] & !(o[5] & m[2]);
    e0 = m[1] & !o[2] | o[0] & !(o[5] & m[0]);
    d = !(m[9] | m[6] | q | m[7] & e1 & !o[1]) & (o[3] | m[10] & a);
    return {m[15], m[14], q, 1'b0, d, v, e1, e0};
  endfunction
  task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_errors++;
      give_verdict;
    end
  end
  task automatic meas(input logic [15:0] m);
    @(posedge meas_clk);
    #1;
    mv = m;
    meas_valid = 1'b1;
    @(posedge meas_clk);
    #1;
    meas_valid = 1'b0;
    exp_f = nf(exp_f, m, arm);
    arm = m[8] | arm & !m[10];
    repeat (30) @(posedge clk);
    chk("flags", status_low_byte, exp_f);
  endtask
  task automatic cfg(input logic [7:0] d);
    @(posedge clk);
    #1;
    cfg_addr = gfs_pkg::CFG_SEAL_ADDR;
    cfg_data = d;
    cfg_wr = 1'b1;
    @(posedge clk);
    #1;
    cfg_wr = 1'b0;
    cfg_done = 1'b1;
    repeat (3) @(posedge clk);
    chk("seal", sealed_access_mode, d == gfs_pkg::CFG_SEAL_KEY);
  endtask
  task automatic op(input logic w, input logic [7:0] c, input int n, input logic [3:0] e);
    if (w) gfs_host_model_inst.wr(c, rnd, n, nak);
    else gfs_host_model_inst.rd(c, n, rdat);
    repeat (4) @(posedge clk);
    chk("error", error_code, e);
  endtask
  initial begin
    status_high_byte = 8'($random(seed));
    repeat (20) @(posedge clk);
    #1;
    srst = 1'b0;
    repeat (5) @(posedge clk);
    op(0, 8'h00, 2, gfs_pkg::ERR_BUSY);
    cfg(8'h00);
    op(0, gfs_pkg::CMD_FLAGS, 2, gfs_pkg::ERR_RESERVED);
    foreach (vec[i]) meas(vec[i]);
    repeat (12) meas(16'($random(seed)));
    op(0, gfs_pkg::CMD_FLAGS, 2, gfs_pkg::ERR_OK);
    chk("flags word", rdat, {status_high_byte, exp_f});
    op(1, gfs_pkg::CMD_FLAGS, 2, gfs_pkg::ERR_ACCESS_DEN);
    op(1, 8'h01, 1, gfs_pkg::ERR_BAD_SIZE);
    op(1, 8'h30, 2, gfs_pkg::ERR_UNSUPPORTED);
    op(0, 8'h30, 2, gfs_pkg::ERR_UNSUPPORTED);
    op(0, gfs_pkg::CMD_BATT_STAT, 2, gfs_pkg::ERR_OK);
    chk("error word", rdat[3:0], gfs_pkg::ERR_UNSUPPORTED);
    op(0, 8'h00, 3, gfs_pkg::ERR_OVER_UNDER);
    for (int i = 0; i < 5; i++) begin
      if (i == 2) cfg(gfs_pkg::CFG_SEAL_KEY);
      rnd = 16'($random(seed));
      op(1, 8'(i), 2, gfs_pkg::ERR_OK);
      chk("ack", nak, 1'b0);
      op(0, 8'(i), 2, gfs_pkg::ERR_OK);
      chk("word", rdat, rnd);
    end
    op(0, gfs_pkg::CMD_FLAGS, 2, gfs_pkg::ERR_OK);
    op(1, 8'h05, 2, gfs_pkg::ERR_ACCESS_DEN);
    chk("nack", nak, 1'b1);
    cfg(8'h00);
    give_verdict;
  end
endmodule
